// File: design/gpr_params.svh
`ifndef GPR_PARAMS_SVH
`define GPR_PARAMS_SVH

// Register offsets within configuration function 0.
`define GPR_IN_OFS   8'hAC
`define GPR_OUT_OFS  8'hAE
// Only configuration function 0 maps these registers.
`define GPR_FUNC0    3'h0
// Reset value of the output value bits.
`define GPR_OUT_RST  5'h00
// Reset value of the synchroniser and level flops.
`define GPR_SYNC_RST 5'h00
// Value of the reserved bits 15 to 5.
`define GPR_RESERVED_BITS_VAL 11'h000

`endif

// File: design/gpr_pkg.sv
`default_nettype none

package gpr_pkg;

  // One configuration access, held for one cycle with req high.
  typedef struct packed {
    logic        req;
    logic        wr;
    logic [2:0]  func;
    logic [7:0]  offset;
    logic [1:0]  be;
    logic [15:0] wdata;
  } gpr_cfg_req_t;

  // Answer one cycle after the request.
  typedef struct packed {
    logic        ack;
    logic [15:0] rdata;
  } gpr_cfg_rsp_t;

endpackage : gpr_pkg

`default_nettype wire

// File: design/gpr_sync.sv
`default_nettype none
`include "gpr_params.svh"

module gpr_sync (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [4:0] pin_in,
  output logic      [4:0] level_q
);

  logic [4:0] s1_q;
  logic [4:0] s2_q;
  logic [4:0] s3_q;

  genvar k;
  generate
    for (k = 0; k < 5; k++) begin : g_bit
      // Three flops; the level follows once the last two agree.
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          s1_q[k]    <= 1'b0;
          s2_q[k]    <= 1'b0;
          s3_q[k]    <= 1'b0;
          level_q[k] <= 1'b0;
        end else begin
          s1_q[k] <= pin_in[k];
          s2_q[k] <= s1_q[k];
          s3_q[k] <= s2_q[k];
          if (s2_q[k] == s3_q[k]) begin
            level_q[k] <= s3_q[k];
          end
        end
      end
    end
  endgenerate

  a_sync_agree: assert property (@(posedge clk) disable iff (!rst_b)
    $changed(level_q) |-> ($past(s2_q) == $past(s3_q))
      && (level_q == $past(s3_q)))
    else $error("Input level changed without agreeing stages.");

endmodule : gpr_sync

`default_nettype wire

// File: design/gpr_regs.sv
`default_nettype none
`include "gpr_params.svh"

// What this block does
// - Read-only input register at ACh, function 0.
// - Bits 4..0 map terminals 5,4,2,1,0.
// - Input register writes ignored, no stored state.
// - Bits 15..5 read zero, ignore writes.
// - Output register at AEh resets to zero.
// - Output bits drive terminals when selected.
// - Output reads return last written values.
module gpr_regs (
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  input  wire gpr_pkg::gpr_cfg_req_t cfg_req,
  output var  gpr_pkg::gpr_cfg_rsp_t cfg_rsp_q,
  input  wire logic [6:0]            terminal_in,
  input  wire logic [4:0]            gpo_select,
  output logic      [6:0]            terminal_out_q,
  output logic      [6:0]            terminal_oe_q
);

  logic [4:0]            in_level;
  logic [4:0]            out_q;
  logic                  hit_func0;
  logic                  hit_in;
  logic                  hit_out;
  logic                  rd_in;
  logic                  rd_out;
  logic                  wr_out;
  logic                  wrote_q;
  gpr_pkg::gpr_cfg_rsp_t rsp_d;
  wire logic [6:0]       term_val;
  wire logic [6:0]       term_sel;

  gpr_sync u_sync (
    .clk     (clk),
    .rst_b   (rst_b),
    .pin_in  ({terminal_in[5:4], terminal_in[2:0]}),
    .level_q (in_level)
  );

  // Address decode; other functions see an empty space.
  assign hit_func0 = cfg_req.req && (cfg_req.func == `GPR_FUNC0);
  assign hit_in    = hit_func0
                     && ({cfg_req.offset[7:1], 1'b0} == `GPR_IN_OFS);
  assign hit_out   = hit_func0
                     && ({cfg_req.offset[7:1], 1'b0} == `GPR_OUT_OFS);
  assign rd_in     = hit_in && !cfg_req.wr;
  assign rd_out    = hit_out && !cfg_req.wr;
  assign wr_out    = hit_out && cfg_req.wr && cfg_req.be[0];

  // Output value bits; only the low byte lane carries them.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      out_q <= `GPR_OUT_RST;
    end else if (hit_out && cfg_req.wr && cfg_req.be[0]) begin
      out_q <= cfg_req.wdata[4:0];
    end
  end

  // Read answer, formed here and registered on the next edge.
  always_comb begin
    rsp_d     = '0;
    rsp_d.ack = cfg_req.req;
    if (rd_in) begin
      rsp_d.rdata = {`GPR_RESERVED_BITS_VAL, in_level};
    end else if (rd_out) begin
      rsp_d.rdata = {`GPR_RESERVED_BITS_VAL, out_q};
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_rsp_q <= '0;
    end else begin
      cfg_rsp_q <= rsp_d;
    end
  end

  // Terminals 3 and 6 carry no output bit and are never driven here.
  assign term_val[3] = 1'b0;
  assign term_val[6] = 1'b0;
  assign term_sel[3] = 1'b0;
  assign term_sel[6] = 1'b0;

  genvar k;
  generate
    for (k = 0; k < 5; k++) begin : g_term
      localparam int term_idx = (k < 3) ? k : k + 1;
      assign term_val[term_idx] = out_q[k];
      assign term_sel[term_idx] = gpo_select[k];

      a_term_drive: assert property (@(posedge clk) disable iff (!rst_b)
        1'b1 |=> terminal_oe_q[term_idx] == $past(gpo_select[k])
          && terminal_out_q[term_idx] == $past(out_q[k]))
        else $error("Terminal drive does not follow its output bit.");
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      terminal_out_q <= 7'h00;
      terminal_oe_q  <= 7'h00;
    end else begin
      terminal_out_q <= term_val;
      terminal_oe_q  <= term_sel;
    end
  end

  // Helper for the reset check.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wrote_q <= 1'b0;
    end else if (hit_out && cfg_req.wr && cfg_req.be[0]) begin
      wrote_q <= 1'b1;
    end
  end

  a_in_readback: assert property (@(posedge clk) disable iff (!rst_b)
    hit_in && !cfg_req.wr |=> cfg_rsp_q.ack
      && cfg_rsp_q.rdata == {11'h000, $past(in_level)})
    else $error("Input register read returned wrong data.");

  a_in_nowrite: assert property (@(posedge clk) disable iff (!rst_b)
    hit_in && cfg_req.wr |=> $stable(out_q))
    else $error("Input register write changed state.");

  a_reserved_bits_zero: assert property (@(posedge clk) disable iff (!rst_b)
    cfg_rsp_q.ack |-> cfg_rsp_q.rdata[15:5] == 11'h000)
    else $error("Reserved bits read nonzero.");

  a_out_reset: assert property (@(posedge clk) disable iff (!rst_b)
    !wrote_q |-> out_q == 5'h00)
    else $error("Output register left reset value unwritten.");

  a_out_pins: assert property (@(posedge clk) disable iff (!rst_b)
    1'b1 |=> terminal_out_q == {1'b0, $past(out_q[4:3]), 1'b0,
      $past(out_q[2:0])} && terminal_oe_q[3] == 1'b0
      && terminal_oe_q[5] == $past(gpo_select[4]))
    else $error("Terminal drive does not follow output value.");

  a_out_write: assert property (@(posedge clk) disable iff (!rst_b)
    hit_out && cfg_req.wr && cfg_req.be[0]
      |=> out_q == $past(cfg_req.wdata[4:0]))
    else $error("Output register write not stored.");

  a_out_readback: assert property (@(posedge clk) disable iff (!rst_b)
    hit_out && !cfg_req.wr |=> cfg_rsp_q.rdata == {11'h000, $past(out_q)})
    else $error("Output register read wrong.");

  a_func_other: assert property (@(posedge clk) disable iff (!rst_b)
    cfg_req.req && cfg_req.func != 3'h0
      |=> cfg_rsp_q.ack && cfg_rsp_q.rdata == 16'h0000 && $stable(out_q))
    else $error("Access outside function 0 had an effect.");

  // Checks on the register answer and the function decode.
  a_ack_follow: assert property (@(posedge clk) disable iff (!rst_b)
    cfg_rsp_q.ack == $past(cfg_req.req))
    else $error("Answer did not follow the request by one cycle.");

  a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_b)
    !cfg_rsp_q.ack |-> cfg_rsp_q.rdata == 16'h0000)
    else $error("Read data not zero outside an answer.");

  a_unmapped_zero: assert property (@(posedge clk) disable iff (!rst_b)
    hit_func0 && !hit_in && !hit_out
      |=> cfg_rsp_q.ack && cfg_rsp_q.rdata == 16'h0000)
    else $error("Unmapped offset returned data.");

  a_write_zero: assert property (@(posedge clk) disable iff (!rst_b)
    cfg_req.req && cfg_req.wr |=> cfg_rsp_q.rdata == 16'h0000)
    else $error("Write answered with read data.");

  a_in_write_ack: assert property (@(posedge clk) disable iff (!rst_b)
    hit_in && cfg_req.wr |=> cfg_rsp_q.ack)
    else $error("Input register write not answered.");

  a_func_decode: assert property (@(posedge clk) disable iff (!rst_b)
    cfg_req.req && cfg_req.func != `GPR_FUNC0 |-> !hit_in && !hit_out)
    else $error("Register decoded outside function 0.");

  // Checks on the output register and the terminals.
  a_be_guard: assert property (@(posedge clk) disable iff (!rst_b)
    hit_out && cfg_req.wr && !cfg_req.be[0] |=> $stable(out_q))
    else $error("Write without the low byte lane changed output bits.");

  a_out_hold: assert property (@(posedge clk) disable iff (!rst_b)
    !wr_out |=> $stable(out_q))
    else $error("Output bits changed without a write.");

  a_out_rst_pins: assert property (@(posedge clk) disable iff (!rst_b)
    !wrote_q |-> terminal_out_q == 7'h00)
    else $error("Terminal values left reset before a write.");

  a_oe_map: assert property (@(posedge clk) disable iff (!rst_b)
    1'b1 |=> terminal_oe_q == {1'b0, $past(gpo_select[4:3]), 1'b0,
      $past(gpo_select[2:0])})
    else $error("Terminal enables do not follow the selection.");

  a_sel_off: assert property (@(posedge clk) disable iff (!rst_b)
    gpo_select == 5'h00 |=> terminal_oe_q == 7'h00)
    else $error("Terminal driven while no output was selected.");

  a_term_idle: assert property (@(posedge clk) disable iff (!rst_b)
    terminal_oe_q[6] == 1'b0 && terminal_out_q[3] == 1'b0
      && terminal_out_q[6] == 1'b0)
    else $error("Unused terminal driven.");

  // Scenario covers.
  c_in_read: cover property (@(posedge clk) disable iff (!rst_b)
    hit_in && !cfg_req.wr ##1 cfg_rsp_q.rdata[4:0] != 5'h00);
  c_out_write: cover property (@(posedge clk) disable iff (!rst_b)
    hit_out && cfg_req.wr && cfg_req.wdata[4:0] == 5'h1f);
  c_func_other: cover property (@(posedge clk) disable iff (!rst_b)
    cfg_req.req && cfg_req.func == 3'h1 && cfg_req.wr);
  c_be_high: cover property (@(posedge clk) disable iff (!rst_b)
    hit_out && cfg_req.wr && !cfg_req.be[0]);
  c_loopback: cover property (@(posedge clk) disable iff (!rst_b)
    rd_in && (terminal_oe_q != 7'h00));

endmodule : gpr_regs

`default_nettype wire

// File: dv/gpr_board.sv
`default_nettype none
module gpr_board (
  input  wire logic [6:0] ext_lvl,
  input  wire logic [6:0] drv_val,
  input  wire logic [6:0] drv_oe,
  output logic      [6:0] pin_lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  // A driven terminal shows the device value, any other the board level.
  assign pin_lvl = (drv_oe & drv_val) | (~drv_oe & ext_lvl);
endmodule : gpr_board
`default_nettype wire

// File: dv/general_purpose_io_regs_tb.sv
`default_nettype none
module general_purpose_io_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  clk;
  logic                  rst_b;
  gpr_pkg::gpr_cfg_req_t rq;
  gpr_pkg::gpr_cfg_rsp_t rs;
  logic [4:0]            sel;
  logic [6:0]            ext;
  logic [6:0]            pin;
  logic [6:0]            tout;
  logic [6:0]            toe;
  logic [15:0]           rd;
  int                    errors;
  int                    tests_run;
  gpr_regs i_dut (.clk(clk), .rst_b(rst_b), .cfg_req(rq), .cfg_rsp_q(rs),
    .terminal_in(pin), .gpo_select(sel), .terminal_out_q(tout),
    .terminal_oe_q(toe));
  gpr_board i_board (.ext_lvl(ext), .drv_val(tout), .drv_oe(toe),
    .pin_lvl(pin));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [2:0] f,
                     input logic [7:0] o, input logic [15:0] d,
                     input logic [1:0] b = 2'h3);
    @(negedge clk);
    rq = '{1'b1, w, f, o, b, d};
    @(negedge clk);
    rd = rs.ack ? rs.rdata : 16'hxxxx;
    rq = '0;
  endtask : acc
  task automatic t_input();
    acc(1'b0, 3'h0, 8'hae, 16'h0000);
    chk(rd, 16'h0000);
    ext = 7'h35;
    repeat (6) @(negedge clk);
    acc(1'b1, 3'h0, 8'hac, 16'hffff);
    acc(1'b0, 3'h0, 8'hac, 16'h0000);
    chk(rd, 16'h001d);
    ext = 7'h4a;
    repeat (6) @(negedge clk);
    acc(1'b0, 3'h0, 8'had, 16'h0000);
    chk(rd, 16'h0002);
    ext = 7'h00;
    acc(1'b0, 3'h0, 8'hac, 16'h0000);
    chk(rd, 16'h0002);
    acc(1'b0, 3'h0, 8'hb0, 16'h0000);
    chk(rd, 16'h0000);
  endtask : t_input
  task automatic t_output();
    acc(1'b1, 3'h0, 8'hae, 16'hffff);
    acc(1'b0, 3'h0, 8'hae, 16'h0000);
    chk(rd, 16'h001f);
    acc(1'b1, 3'h1, 8'hae, 16'h0000);
    acc(1'b0, 3'h0, 8'haf, 16'h0000);
    chk(rd, 16'h001f);
    acc(1'b1, 3'h0, 8'hae, 16'h000a);
    sel = 5'h1f;
    repeat (3) @(negedge clk);
    chk({9'h000, tout}, 16'h0012);
    chk({9'h000, toe}, 16'h0037);
    repeat (5) @(negedge clk);
    acc(1'b0, 3'h0, 8'hac, 16'h0000);
    chk(rd, 16'h000a);
    sel = 5'h00;
    repeat (3) @(negedge clk);
    chk({9'h000, toe}, 16'h0000);
    acc(1'b0, 3'h0, 8'hae, 16'h0000);
    chk(rd, 16'h000a);
    acc(1'b1, 3'h0, 8'hae, 16'h0000, 2'h2);
    acc(1'b0, 3'h0, 8'hae, 16'h0000);
    chk(rd, 16'h000a);
  endtask : t_output
  task automatic t_reset();
    acc(1'b1, 3'h0, 8'hae, 16'h0015);
    sel = 5'h1f;
    repeat (3) @(negedge clk);
    chk({9'h000, tout}, 16'h0025);
    rst_b = 1'b0;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    chk({9'h000, tout}, 16'h0000);
    chk({9'h000, toe}, 16'h0000);
    acc(1'b0, 3'h0, 8'hae, 16'h0000);
    chk(rd, 16'h0000);
    sel = 5'h00;
  endtask : t_reset
  task automatic print_verdict();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    errors = 0;
    tests_run = 0;
    rst_b = 1'b0;
    rq = '0;
    sel = 5'h00;
    ext = 7'h00;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    t_input();
    t_output();
    t_reset();
    print_verdict();
  end
  initial begin
    repeat (2000) @(posedge clk);
    errors++;
    print_verdict();
  end
endmodule : general_purpose_io_regs_tb
`default_nettype wire
